// ---- rtl/dcd_cal_config.sv ----
/*
 * divider calibration configuration register with AXI4-Lite slave,
 * slow-filter sequencing, fast-lock coefficient choice, phase-wrap test.
 * assumes engine inputs synchronous to ref_clk; one clock domain.
 */
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
// Contract
// R01: gain shift field 31:27, reset 0x10, drives slow-filter gain.
// R02: slow mode starts only after slow-start delay following accel end.
// R03: software keeps slow enable clear when integer or holdover set.
// R04: fast-lock select codes 0..3 give coefficients 0x0B..0x0E.
// R05: fast-lock bit replaces normal coefficient with fast-lock coefficient.
// R06: fast lock forced during the accelerated fast-lock window.
// R07: software sets fast-lock bit only for manual fast lock.
// R08: device forces fast lock at startup before clocks enable.
// R09: decimator field 20:16, reset 0xA, at most ten.
// R10: bit 15 enables robust transient state decoding, reset one.
// R11: bits 14:13 pick wrap test: nearest by 34, above 17, above 12.
// R12: software leaves wrap selection at zero normally.
// R13: normal coefficient field 12:8, reset 0x18, at most 24.
// R14: bit 25 stored spare without effect; bit 26 reads zero.
// R15: one slow update rate shared by every divider.
// R16: integer-mode bit 4 forces correction output to zero.
// R17: holdover bit 5 holds calibration in holdover.
// R18: fields read back last written value or reset value.
`timescale 1ns/1ps
module dcd_cal_config
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // axi4-lite write
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [5:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // axi4-lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [5:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // calibration engine
   input  wire logic        accelActive,
   input  wire logic        accelFlWindow,
   input  wire logic        startupCalDone,
   input  wire logic [15:0] slowStartDelay,
   input  wire logic [7:0]  slowRateCfg,
   input  wire logic [14:0] correctionIn,
   input  wire logic [7:0]  groDelta,
   // configuration out
   output logic [4:0]       gainShift,
   output logic [4:0]       decimCoef,
   output logic [4:0]       lpfCoef,
   output logic             robustGroEn,
   output logic             slowMode,
   output logic [7:0]       slowUpdateRate,
   output logic             fastLockActive,
   output logic             calHold,
   output logic             clocksEnable,
   output logic [14:0]      correctionOut,
   output logic             phaseWrapped
);
   typedef enum logic [1:0] {SLOW_WAIT, SLOW_DELAY, SLOW_ARMED} slow_state_t;

   logic [31:0] cfg;
   logic [31:0] next_cfg;
   logic [31:0] status;
   logic [31:0] readWord;
   logic        awHeld;
   logic        wHeld;
   logic [5:0]  awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0]  wStrbHeld;
   logic        cfgHit;
   logic        readOk;
   logic        accelPrev;
   logic        startupDone;
   logic        delayStart;
   logic        delayRunning;
   logic        delayDone;
   logic        flNow;
   logic [4:0]  coefNow;
   logic        wrapNow;
   slow_state_t slowState;

   default clocking checkClk @(posedge ref_clk); endclocking
   default disable iff (rst);

   // ==========================================================
   // bus handshake
   assign awready = !awHeld && !bvalid;
   assign wready  = !wHeld && !bvalid;
   assign arready = !rvalid;
   assign cfgHit  = awAddrHeld[5:2] == dcd_cal_pkg::CFG_INDEX;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         awHeld     <= 1'b0;
         wHeld      <= 1'b0;
         awAddrHeld <= 6'h00;
         wDataHeld  <= 32'h0000_0000;
         wStrbHeld  <= 4'h0;
         bvalid     <= 1'b0;
         bresp      <= dcd_cal_pkg::RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awHeld     <= 1'b1;
            awAddrHeld <= awaddr;
         end
         if (wvalid && wready)
         begin
            wHeld     <= 1'b1;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
         end
         if (awHeld && wHeld && !bvalid)
         begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= (cfgHit || awAddrHeld[5:2] == dcd_cal_pkg::STATUS_INDEX)
                      ? dcd_cal_pkg::RESP_OKAY : dcd_cal_pkg::RESP_DECERR;
         end
         else if (bvalid && bready)
         begin
            bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // configuration register
   always_comb
   begin
      next_cfg = cfg;
      for (int b = 0; b < 4; b++)
      begin
         if (wStrbHeld[b])
         begin
            next_cfg[8*b +: 8] = wDataHeld[8*b +: 8] & dcd_cal_pkg::CFG_WMASK[8*b +: 8]; // R14
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cfg <= dcd_cal_pkg::CFG_RESET; // R01 R09 R10 R13
      end
      else if (awHeld && wHeld && !bvalid && cfgHit)
      begin
         cfg <= next_cfg; // R18
      end
   end

   // ==========================================================
   // read path
   always_comb
   begin
      status = 32'h0000_0000;
      status[dcd_cal_pkg::ST_SLOW_BIT]    = slowMode;
      status[dcd_cal_pkg::ST_FAST_BIT]    = fastLockActive;
      status[dcd_cal_pkg::ST_STARTUP_BIT] = startupDone;
      status[dcd_cal_pkg::ST_WRAP_BIT]    = phaseWrapped;
      status[dcd_cal_pkg::ST_DELAY_BIT]   = delayRunning;
      readOk   = 1'b1;
      readWord = 32'h0000_0000;
      if (araddr[5:2] == dcd_cal_pkg::CFG_INDEX)
      begin
         readWord = cfg; // R18
      end
      else if (araddr[5:2] == dcd_cal_pkg::STATUS_INDEX)
      begin
         readWord = status;
      end
      else
      begin
         readOk = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= dcd_cal_pkg::RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata  <= readWord;
         rresp  <= readOk ? dcd_cal_pkg::RESP_OKAY : dcd_cal_pkg::RESP_DECERR;
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // startup fast lock and slow-filter sequencing
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         startupDone  <= 1'b0;
         clocksEnable <= 1'b0;
         accelPrev    <= 1'b0;
      end
      else
      begin
         accelPrev <= accelActive;
         if (startupCalDone)
         begin
            startupDone <= 1'b1;
         end
         clocksEnable <= startupDone; // R08
      end
   end

   assign delayStart = accelPrev && !accelActive && slowState != SLOW_DELAY;

   slow_start_timer u_timer
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (delayStart),
      .abort   (accelActive),
      .delay   (slowStartDelay),
      .running (delayRunning),
      .done    (delayDone)
   );

   always_ff @(posedge ref_clk)
   begin
      if (rst || accelActive)
      begin
         slowState <= SLOW_WAIT;
      end
      else
      begin
         unique case (slowState)
            SLOW_WAIT:
               if (delayStart)
               begin
                  slowState <= SLOW_DELAY; // R02
               end
            SLOW_DELAY:
               if (delayDone)
               begin
                  slowState <= SLOW_ARMED; // R02
               end
            SLOW_ARMED:
               slowState <= SLOW_ARMED;
         endcase
      end
   end

   // ==========================================================
   // coefficient choice and phase-wrap test
   fast_lock_coef u_coef
   (
      .flSel          (cfg[dcd_cal_pkg::FL_SEL_LO +: 2]),
      .flBit          (cfg[dcd_cal_pkg::FL_BIT]),
      .lpfCfg         (cfg[dcd_cal_pkg::LPF_LO +: 5]),
      .accelFlWindow  (accelFlWindow),
      .startupActive  (!startupDone),
      .fastLockActive (flNow),
      .coef           (coefNow)
   );

   always_comb
   begin
      logic [8:0] d;
      logic [8:0] mag;
      logic [8:0] up;
      logic [8:0] dn;
      d   = {groDelta[7], groDelta};
      mag = d[8] ? 9'(-d) : d;
      up  = 9'(d + dcd_cal_pkg::WRAP_SPAN);
      dn  = 9'(d - dcd_cal_pkg::WRAP_SPAN);
      up  = up[8] ? 9'(-up) : up;
      dn  = dn[8] ? 9'(-dn) : dn;
      unique case (dcd_cal_pkg::wrap_mode_t'(cfg[dcd_cal_pkg::WRAP_LO +: 2]))
         dcd_cal_pkg::WRAP_ABOVE17: wrapNow = mag > dcd_cal_pkg::WRAP_T1; // R11
         dcd_cal_pkg::WRAP_ABOVE12: wrapNow = mag > dcd_cal_pkg::WRAP_T2; // R11
         default:                   wrapNow = (up < mag) || (dn < mag); // R11
      endcase
   end

   // ==========================================================
   // registered outputs to the engine
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         gainShift      <= dcd_cal_pkg::CFG_RESET[dcd_cal_pkg::GAIN_LO +: 5];
         decimCoef      <= dcd_cal_pkg::DECI_MAX;
         lpfCoef        <= dcd_cal_pkg::LPF_MAX;
         robustGroEn    <= dcd_cal_pkg::CFG_RESET[dcd_cal_pkg::ROBUST_BIT];
         slowMode       <= 1'b0;
         slowUpdateRate <= 8'h00;
         fastLockActive <= 1'b1;
         calHold        <= 1'b0;
         correctionOut  <= 15'h0000;
         phaseWrapped   <= 1'b0;
      end
      else
      begin
         gainShift      <= cfg[dcd_cal_pkg::GAIN_LO +: 5]; // R01
         decimCoef      <= (cfg[dcd_cal_pkg::DECI_LO +: 5] > dcd_cal_pkg::DECI_MAX)
                           ? dcd_cal_pkg::DECI_MAX : cfg[dcd_cal_pkg::DECI_LO +: 5]; // R09
         lpfCoef        <= coefNow; // R04 R05 R13
         fastLockActive <= flNow; // R06
         robustGroEn    <= cfg[dcd_cal_pkg::ROBUST_BIT]; // R10
         slowMode       <= slowState == SLOW_ARMED && cfg[dcd_cal_pkg::SLOW_EN_BIT]
                           && !cfg[dcd_cal_pkg::INT_BIT] && !cfg[dcd_cal_pkg::HOLD_BIT]; // R02 R03
         slowUpdateRate <= slowRateCfg; // R15
         calHold        <= cfg[dcd_cal_pkg::HOLD_BIT]; // R17
         correctionOut  <= cfg[dcd_cal_pkg::INT_BIT] ? 15'h0000 : correctionIn; // R16
         phaseWrapped   <= wrapNow;
      end
   end

   // ==========================================================
   // assertions
   property p_gain_follows; 1'b1 |=> gainShift == $past(cfg[31:27]); endproperty
   a_gain_follows: assert property (p_gain_follows) else $error("gain shift off"); // R01
   property p_slow_after_delay; $fell(accelActive) |-> !slowMode ##1 !slowMode; endproperty
   a_slow_after_delay: assert property (p_slow_after_delay) else $error("slow too early"); // R02
   property p_fl_table; flNow && cfg[23:22] == 2'h3 |=> lpfCoef == 5'h0E; endproperty
   a_fl_table: assert property (p_fl_table) else $error("fast coef wrong"); // R04
   property p_normal_coef;
      !flNow && cfg[12:8] <= 5'h18 |=> lpfCoef == $past(cfg[12:8]);
   endproperty
   a_normal_coef: assert property (p_normal_coef) else $error("normal coef wrong"); // R05
   property p_accel_fast; accelFlWindow |=> fastLockActive; endproperty
   a_accel_fast: assert property (p_accel_fast) else $error("no accel fast lock"); // R06
   property p_startup; !startupDone |-> !clocksEnable && flNow; endproperty
   a_startup: assert property (p_startup) else $error("clocks before cal"); // R08
   property p_deci_max; decimCoef <= 5'h0A; endproperty
   a_deci_max: assert property (p_deci_max) else $error("decimator above ten"); // R09
   property p_rsvd_zero; rvalid |-> !(rdata[26]); endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // R14
   property p_int_zero; cfg[4] |=> correctionOut == 15'h0000; endproperty
   a_int_zero: assert property (p_int_zero) else $error("correction not zero"); // R16
   property p_hold; $rose(cfg[5]) |=> calHold [*2]; endproperty
   a_hold: assert property (p_hold) else $error("holdover missed"); // R17

   property p_cov_write; bvalid && bready && bresp == 2'h0; endproperty
   c_cov_write: cover property (p_cov_write);
   property p_cov_slow; $rose(slowMode); endproperty
   c_cov_slow: cover property (p_cov_slow);
   property p_cov_wrap; $rose(phaseWrapped); endproperty
   c_cov_wrap: cover property (p_cov_wrap);
endmodule // dcd_cal_config

// ---- rtl/dcd_cal_pkg.sv ----
/*
 * constants of the divider calibration configuration bank: register
 * indices, field positions, reset values, coefficient tables.
 * assumes a 32-bit AXI4-Lite register bus, one word per register.
 */
package dcd_cal_pkg;
   // ==========================================================
   // register map (index, byte address is four times the index)
   localparam int          ADDR_W       = 6;
   localparam logic [3:0]  CFG_INDEX    = 4'h0;
   localparam logic [3:0]  STATUS_INDEX = 4'h1;
   localparam logic [31:0] CFG_RESET    = 32'h800A_9800;
   localparam logic [31:0] CFG_WMASK    = 32'hFBFF_FF30;
   // ==========================================================
   // configuration fields
   localparam int GAIN_LO     = 27;
   localparam int RSVD_BIT    = 26;
   localparam int SPARE_BIT   = 25;
   localparam int SLOW_EN_BIT = 24;
   localparam int FL_SEL_LO   = 22;
   localparam int FL_BIT      = 21;
   localparam int DECI_LO     = 16;
   localparam int ROBUST_BIT  = 15;
   localparam int WRAP_LO     = 13;
   localparam int LPF_LO      = 8;
   localparam int HOLD_BIT    = 5;
   localparam int INT_BIT     = 4;
   // ==========================================================
   // status fields
   localparam int ST_SLOW_BIT    = 0;
   localparam int ST_FAST_BIT    = 1;
   localparam int ST_STARTUP_BIT = 2;
   localparam int ST_WRAP_BIT    = 3;
   localparam int ST_DELAY_BIT   = 4;
   // ==========================================================
   // coefficients and limits
   localparam logic [4:0] FL_COEF0  = 5'h0B;
   localparam logic [4:0] DECI_MAX  = 5'h0A;
   localparam logic [4:0] LPF_MAX   = 5'h18;
   localparam logic [8:0] WRAP_SPAN = 9'h022;
   localparam logic [8:0] WRAP_T1   = 9'h011;
   localparam logic [8:0] WRAP_T2   = 9'h00C;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {WRAP_NEAREST, WRAP_ABOVE17, WRAP_ABOVE12, WRAP_SPARE} wrap_mode_t;
endpackage

// ---- rtl/fast_lock_coef.sv ----
/*
 * selects the low-pass coefficient: fast-lock table or the normal one.
 * assumes synchronous control levels from the configuration bank.
 */
`timescale 1ns/1ps
module fast_lock_coef
(
   // configuration
   input  wire logic [1:0] flSel,
   input  wire logic       flBit,
   input  wire logic [4:0] lpfCfg,
   // engine state
   input  wire logic       accelFlWindow,
   input  wire logic       startupActive,
   // result
   output logic            fastLockActive,
   output logic [4:0]      coef
);
   always_comb
   begin
      fastLockActive = flBit | accelFlWindow | startupActive; // R05 R06 R08
      if (fastLockActive)
      begin
         coef = dcd_cal_pkg::FL_COEF0 + {3'b000, flSel}; // R04
      end
      else if (lpfCfg > dcd_cal_pkg::LPF_MAX)
      begin
         coef = dcd_cal_pkg::LPF_MAX; // R13
      end
      else
      begin
         coef = lpfCfg; // R13
      end
   end
endmodule // fast_lock_coef

// ---- rtl/slow_start_timer.sv ----
/*
 * counts the slow-start delay after accelerated calibration ends.
 * assumes delay given in reference clock cycles, held during a count.
 */
`timescale 1ns/1ps
module slow_start_timer
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // control
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic [15:0] delay,
   // status
   output logic             running,
   output logic             done
);
   logic [15:0] count;

   always_ff @(posedge ref_clk)
   begin
      if (rst || abort)
      begin
         running <= 1'b0;
         done    <= 1'b0;
         count   <= 16'h0000;
      end
      else if (start)
      begin
         running <= 1'b1;
         done    <= 1'b0;
         count   <= 16'h0000;
      end
      else if (running)
      begin
         if (count == delay)
         begin
            running <= 1'b0;
            done    <= 1'b1; // R02
         end
         else
         begin
            count <= count + 16'h0001;
         end
      end
   end
endmodule // slow_start_timer

// ---- testbench/tb.sv ----
/*
 * self-checking bench of the divider calibration configuration bank.
 * assumes dcd_cal_config and dcd_cal_pkg compiled first; one 100 MHz clock.
 */
`timescale 1ns/1ps
module tb;
   // ==========================================================
   // signals
   logic        ref_clk, rst;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, cfg, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        accelActive, accelFlWindow, startupCalDone, robustGroEn, slowMode;
   logic        fastLockActive, calHold, clocksEnable, phaseWrapped;
   logic [15:0] slowStartDelay;
   logic [7:0]  slowRateCfg, groDelta, slowUpdateRate;
   logic [14:0] correctionIn, correctionOut;
   logic [4:0]  gainShift, decimCoef, lpfCoef;
   int          failures, cmp_count, n;
   logic [9:0]  wcase [9] = '{10'h012, 10'h011, 10'h0EE, 10'h112, 10'h111,
                              10'h20D, 10'h20C, 10'h312, 10'h311};
   logic        wexp  [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

   // ==========================================================
   // device
   dcd_cal_config i_dut
   (
      .ref_clk(ref_clk), .rst(rst),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .accelActive(accelActive), .accelFlWindow(accelFlWindow),
      .startupCalDone(startupCalDone), .slowStartDelay(slowStartDelay),
      .slowRateCfg(slowRateCfg), .correctionIn(correctionIn), .groDelta(groDelta),
      .gainShift(gainShift), .decimCoef(decimCoef), .lpfCoef(lpfCoef),
      .robustGroEn(robustGroEn), .slowMode(slowMode), .slowUpdateRate(slowUpdateRate),
      .fastLockActive(fastLockActive), .calHold(calHold), .clocksEnable(clocksEnable),
      .correctionOut(correctionOut), .phaseWrapped(phaseWrapped)
   );

   always #5 ref_clk = ~ref_clk;

   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // wait n edges, then look between edges
   task automatic settle(input int cycles);
      repeat (cycles) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      logic awHit, wHit, bHit;
      int   k;
      @(posedge ref_clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      bHit = 1'b0;
      k = 0;
      while (!bHit && k < 200)
      begin
         @(negedge ref_clk);
         awHit = awvalid && (awready === 1'b1);
         wHit  = wvalid && (wready === 1'b1);
         bHit  = (bvalid === 1'b1);
         r     = bresp;
         @(posedge ref_clk);
         if (awHit) awvalid <= 1'b0;
         if (wHit) wvalid <= 1'b0;
         k++;
      end
      bready <= 1'b0;
      check({31'h0, bHit}, 32'h0000_0001, "write response");
   endtask

   task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      logic arHit, rHit;
      int   k;
      @(posedge ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      rHit = 1'b0;
      k = 0;
      while (!rHit && k < 200)
      begin
         @(negedge ref_clk);
         arHit = arvalid && (arready === 1'b1);
         rHit  = (rvalid === 1'b1);
         d     = rdata;
         r     = rresp;
         @(posedge ref_clk);
         if (arHit) arvalid <= 1'b0;
         k++;
      end
      rready <= 1'b0;
      check({31'h0, rHit}, 32'h0000_0001, "read response");
   endtask

   task automatic write_cfg(input logic [31:0] d);
      axi_write(6'h00, d, resp);
      check({30'h0, resp}, {30'h0, dcd_cal_pkg::RESP_OKAY}, "cfg write resp");
      settle(2);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      axi_read(6'h00, rd, resp);
      check(rd, dcd_cal_pkg::CFG_RESET, "reset readback");
      settle(1);
      check({27'h0, gainShift}, 32'h0000_0010, "gain at reset");
      check({27'h0, decimCoef}, 32'h0000_000A, "deci at reset");
      check({31'h0, robustGroEn}, 32'h0000_0001, "robust at reset");
      check({31'h0, fastLockActive}, 32'h0000_0001, "startup fast lock");
      check({27'h0, lpfCoef}, 32'h0000_000B, "startup coef");
      check({31'h0, clocksEnable}, 32'h0000_0000, "clocks before cal");
      @(posedge ref_clk);
      startupCalDone <= 1'b1;
      settle(10);
      check({31'h0, clocksEnable}, 32'h0000_0001, "clocks after cal");
      check({31'h0, fastLockActive}, 32'h0000_0000, "fast lock off");
      check({27'h0, lpfCoef}, 32'h0000_0018, "normal coef");
   endtask

   task automatic t_access;
      write_cfg(32'hFEFF_FFFF);
      axi_read(6'h00, rd, resp);
      check(rd, dcd_cal_pkg::CFG_WMASK & 32'hFEFF_FFFF, "all ones readback");
      write_cfg(dcd_cal_pkg::CFG_RESET | 32'h0200_0000);
      axi_read(6'h00, rd, resp);
      check(rd, dcd_cal_pkg::CFG_RESET | 32'h0200_0000, "spare readback");
      axi_write(6'h04, 32'h0000_0000, resp);
      check({30'h0, resp}, {30'h0, dcd_cal_pkg::RESP_OKAY}, "status write");
      axi_write(6'h20, 32'h0000_0000, resp);
      check({30'h0, resp}, {30'h0, dcd_cal_pkg::RESP_DECERR}, "unmapped write");
      axi_read(6'h20, rd, resp);
      check({30'h0, resp}, {30'h0, dcd_cal_pkg::RESP_DECERR}, "unmapped read");
      axi_read(6'h00, rd, resp);
      check(rd, dcd_cal_pkg::CFG_RESET | 32'h0200_0000, "cfg kept");
   endtask

   task automatic t_fast;
      for (int s = 0; s < 4; s++)
      begin
         cfg = dcd_cal_pkg::CFG_RESET;
         cfg[23:22] = 2'(s);
         cfg[21] = 1'b1;
         write_cfg(cfg);
         check({27'h0, lpfCoef}, 32'h0000_000B + 32'(s), "fast coef");
         check({31'h0, fastLockActive}, 32'h0000_0001, "manual fast");
      end
      cfg[21] = 1'b0;
      write_cfg(cfg);
      check({27'h0, lpfCoef}, 32'h0000_0018, "normal again");
      @(posedge ref_clk);
      accelFlWindow <= 1'b1;
      settle(2);
      check({27'h0, lpfCoef}, 32'h0000_000E, "accel window coef");
      check({31'h0, fastLockActive}, 32'h0000_0001, "accel window");
      @(posedge ref_clk);
      accelFlWindow <= 1'b0;
   endtask

   task automatic t_fields;
      write_cfg(32'h7A1F_1F00);
      check({27'h0, gainShift}, 32'h0000_000F, "gain");
      check({27'h0, decimCoef}, 32'h0000_000A, "deci clamp");
      check({27'h0, lpfCoef}, 32'h0000_0018, "lpf clamp");
      check({31'h0, robustGroEn}, 32'h0000_0000, "robust off");
      axi_read(6'h00, rd, resp);
      check(rd, 32'h7A1F_1F00, "field readback");
      write_cfg(32'h8807_8500);
      check({27'h0, decimCoef}, 32'h0000_0007, "deci");
      check({27'h0, lpfCoef}, 32'h0000_0005, "lpf");
      check({27'h0, gainShift}, 32'h0000_0011, "gain 17");
   endtask

   task automatic t_modes;
      @(posedge ref_clk);
      correctionIn <= 15'h1234;
      slowRateCfg  <= 8'h5A;
      write_cfg(dcd_cal_pkg::CFG_RESET);
      check({17'h0, correctionOut}, 32'h0000_1234, "correction");
      check({24'h0, slowUpdateRate}, 32'h0000_005A, "shared rate");
      write_cfg(dcd_cal_pkg::CFG_RESET | 32'h0000_0010);
      check({17'h0, correctionOut}, 32'h0000_0000, "integer zero");
      write_cfg(dcd_cal_pkg::CFG_RESET | 32'h0000_0020);
      check({31'h0, calHold}, 32'h0000_0001, "holdover");
      write_cfg(dcd_cal_pkg::CFG_RESET);
      check({31'h0, calHold}, 32'h0000_0000, "holdover off");
   endtask

   task automatic t_slow;
      @(posedge ref_clk);
      slowStartDelay <= 16'h000A;
      accelActive    <= 1'b1;
      write_cfg(dcd_cal_pkg::CFG_RESET | 32'h0100_0000);
      check({31'h0, slowMode}, 32'h0000_0000, "slow during accel");
      @(posedge ref_clk);
      accelActive <= 1'b0;
      settle(5);
      check({31'h0, slowMode}, 32'h0000_0000, "slow in delay");
      n = 5;
      while (slowMode !== 1'b1 && n < 40)
      begin
         settle(1);
         n++;
      end
      check({31'h0, (n >= 11 && n <= 20)}, 32'h0000_0001, "slow start time");
      axi_read(6'h04, rd, resp);
      check(rd, 32'h0000_0005, "status after slow start");
   endtask

   task automatic t_wrap;
      for (int i = 0; i < 9; i++)
      begin
         cfg = dcd_cal_pkg::CFG_RESET;
         cfg[14:13] = wcase[i][9:8];
         write_cfg(cfg);
         @(posedge ref_clk);
         groDelta <= wcase[i][7:0];
         settle(2);
         check({31'h0, phaseWrapped}, {31'h0, wexp[i]}, "wrap decision");
      end
      write_cfg(dcd_cal_pkg::CFG_RESET);
      check({31'h0, phaseWrapped}, 32'h0000_0000, "wrap default");
   endtask

   // ==========================================================
   // verdict
   task automatic tally_and_finish;
      $display("failures %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      $display("wrong value at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial
   begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 6'h00;
      araddr = 6'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      {accelActive, accelFlWindow, startupCalDone} = 3'h0;
      slowStartDelay = 16'h0000;
      slowRateCfg = 8'h00;
      correctionIn = 15'h0000;
      groDelta = 8'h00;
      failures = 0;
      cmp_count = 0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_access();
      t_fast();
      t_fields();
      t_modes();
      t_slow();
      t_wrap();
      tally_and_finish();
   end
endmodule // tb
